// *** core/bdm_core_map.sv ***
`timescale 1ns/10ps
module bdm_core_map (
	input wire logic clk,
	input wire logic arst_n,
	input bdm_pkg::bdm_req_t req,
	input bdm_pkg::bdm_ctx_t live_ctx,
	input wire logic irq_entry,
	input wire logic irq_exit,
	input bdm_pkg::bdm_stack_ctl_t stk,
	input wire logic stack_fault_reset_enable,
	input wire logic fault_flag_clear,
	input wire logic [7:0] periph_rdata,
	output bdm_pkg::bdm_periph_t periph,
	output bdm_pkg::bdm_rsp_t rsp,
	output logic restore_valid,
	output bdm_pkg::bdm_ctx_t restore_ctx,
	output logic [14:0] tos,
	output logic stack_reset_req,
	output logic stack_overflow,
	output logic stack_underflow
);
	typedef struct packed {
		logic rsp_valid;
		bdm_pkg::bdm_cls_t cls;
		logic [11:0] addr;
		logic [14:0] prog_addr;
		logic [7:0] local_rdata;
		logic [4:0] sp;
		logic ovf;
		logic unf;
		logic rst_req;
	} bdm_state_t;

	typedef struct packed {
		bdm_pkg::bdm_ctx_t shadow;
		logic [15:0][14:0] stack;
	} bdm_keep_t;

	bdm_state_t st;
	bdm_state_t next_st;
	bdm_keep_t kp;
	bdm_keep_t next_kp;
	logic [15:0] ea;
	bdm_pkg::bdm_cls_t cls;
	logic [9:0] ram_idx;
	logic [14:0] prog_addr;
	logic [7:0] ram_q;
	logic wr;
	logic [14:0] tos_cur;

	assign tos_cur = st.sp[4] ? 15'h0000 : kp.stack[st.sp[3:0]];

	always_comb begin
		next_st = st;
		next_kp = kp;
		ea = 16'h0000;
		cls = bdm_pkg::BDM_CLS_NONE;
		ram_idx = 10'h000;
		prog_addr = 15'h0000;
		wr = req.valid && req.we;
		unique case (req.mode)
			bdm_pkg::BDM_DIRECT: ea = {4'h0, live_ctx.bank, req.offset};
			bdm_pkg::BDM_IND0: ea = live_ctx.ptr0;
			bdm_pkg::BDM_IND1: ea = live_ctx.ptr1;
			bdm_pkg::BDM_REL: ea = 16'h0000;
		endcase
		if (req.mode == bdm_pkg::BDM_REL) begin
			cls = bdm_pkg::BDM_CLS_PROG;
			prog_addr = req.pc + {{6{req.rel_disp[8]}}, req.rel_disp};
		end else if (ea >= bdm_pkg::PROG_BASE) begin
			cls = bdm_pkg::BDM_CLS_PROG;
			prog_addr = ea[14:0];
		end else if (ea >= bdm_pkg::LINEAR_BASE && ea <= bdm_pkg::LINEAR_LAST) begin
			cls = bdm_pkg::BDM_CLS_RAM;
			ram_idx = 10'(ea - bdm_pkg::LINEAR_BASE);
		end else if (ea < bdm_pkg::BANKED_LIMIT) begin
			if (ea[6:0] < bdm_pkg::PERIPH_FIRST) begin
				cls = bdm_pkg::BDM_CLS_CORE;
			end else if (ea[6:0] <= bdm_pkg::PERIPH_LAST) begin
				cls = bdm_pkg::BDM_CLS_PERIPH;
			end else if (ea[6:0] >= bdm_pkg::COMMON_FIRST) begin
				cls = bdm_pkg::BDM_CLS_RAM;
				ram_idx = bdm_pkg::COMMON_BASE + 10'(ea[6:0] - bdm_pkg::COMMON_FIRST);
			end else if (ea[11:7] == bdm_pkg::TOP_BANK && ea[6:0] >= bdm_pkg::SPECIAL_FIRST) begin
				cls = bdm_pkg::BDM_CLS_SPECIAL;
			end else if (ea[11:7] < bdm_pkg::RAM_BANKS) begin
				cls = bdm_pkg::BDM_CLS_RAM;
				ram_idx = 10'(ea[11:7]) * bdm_pkg::RAM_PER_BANK
					+ 10'(ea[6:0] - bdm_pkg::RAM_FIRST);
			end
		end

		next_st.rsp_valid = req.valid;
		next_st.cls = cls;
		next_st.addr = ea[11:0];
		next_st.prog_addr = prog_addr;
		next_st.local_rdata = 8'h00;
		next_st.rst_req = 1'b0;
		if (cls == bdm_pkg::BDM_CLS_PERIPH) begin
			next_st.local_rdata = periph_rdata;
		end else if (cls == bdm_pkg::BDM_CLS_SPECIAL) begin
			unique case (ea[11:0])
				bdm_pkg::ADDR_STATUS_SHADOW: next_st.local_rdata = {5'h00, kp.shadow.status};
				bdm_pkg::ADDR_W_SHAD: next_st.local_rdata = kp.shadow.w;
				bdm_pkg::ADDR_BANK_SHAD: next_st.local_rdata = {3'h0, kp.shadow.bank};
				bdm_pkg::ADDR_PROG_LATCH_SHADOW: next_st.local_rdata = {1'b0, kp.shadow.prog_latch};
				bdm_pkg::ADDR_P0L_SHAD: next_st.local_rdata = kp.shadow.ptr0[7:0];
				bdm_pkg::ADDR_P0H_SHAD: next_st.local_rdata = kp.shadow.ptr0[15:8];
				bdm_pkg::ADDR_P1L_SHAD: next_st.local_rdata = kp.shadow.ptr1[7:0];
				bdm_pkg::ADDR_P1H_SHAD: next_st.local_rdata = kp.shadow.ptr1[15:8];
				bdm_pkg::ADDR_STACK_PTR: next_st.local_rdata = {3'h0, st.sp};
				bdm_pkg::ADDR_TOS_LOW: next_st.local_rdata = tos_cur[7:0];
				bdm_pkg::ADDR_TOS_HIGH: next_st.local_rdata = {1'b0, tos_cur[14:8]};
				default: next_st.local_rdata = 8'h00;
			endcase
			if (wr) begin
				unique case (ea[11:0])
					bdm_pkg::ADDR_STATUS_SHADOW: next_kp.shadow.status = req.wdata[2:0];
					bdm_pkg::ADDR_W_SHAD: next_kp.shadow.w = req.wdata;
					bdm_pkg::ADDR_BANK_SHAD: next_kp.shadow.bank = req.wdata[4:0];
					bdm_pkg::ADDR_PROG_LATCH_SHADOW: next_kp.shadow.prog_latch = req.wdata[6:0];
					bdm_pkg::ADDR_P0L_SHAD: next_kp.shadow.ptr0[7:0] = req.wdata;
					bdm_pkg::ADDR_P0H_SHAD: next_kp.shadow.ptr0[15:8] = req.wdata;
					bdm_pkg::ADDR_P1L_SHAD: next_kp.shadow.ptr1[7:0] = req.wdata;
					bdm_pkg::ADDR_P1H_SHAD: next_kp.shadow.ptr1[15:8] = req.wdata;
					bdm_pkg::ADDR_STACK_PTR: next_st.sp = req.wdata[4:0];
					bdm_pkg::ADDR_TOS_LOW: begin
						if (!st.sp[4]) begin
							next_kp.stack[st.sp[3:0]][7:0] = req.wdata;
						end
					end
					bdm_pkg::ADDR_TOS_HIGH: begin
						if (!st.sp[4]) begin
							next_kp.stack[st.sp[3:0]][14:8] = req.wdata[6:0];
						end
					end
					default: next_st.sp = st.sp;
				endcase
			end
		end

		// push and pop, hardware wins over software pointer writes
		if (stk.push) begin
			if (st.sp == bdm_pkg::STACK_PTR_FULL) begin
				// overflow flag, reset only when enabled
				next_st.ovf = 1'b1;
				next_st.rst_req = stack_fault_reset_enable;
				next_st.sp = st.sp;
			end else begin
				next_st.sp = st.sp + 5'h01;
				next_kp.stack[4'(st.sp + 5'h01)] = stk.data;
			end
		end else if (stk.pop) begin
			if (st.sp == bdm_pkg::STACK_PTR_RESET) begin
				// underflow flag, reset only when enabled
				next_st.unf = 1'b1;
				next_st.rst_req = stack_fault_reset_enable;
				next_st.sp = st.sp;
			end else begin
				next_st.sp = st.sp - 5'h01;
			end
		end
		// Clear loses to a fault in the same cycle
		if (fault_flag_clear) begin
			next_st.ovf = (stk.push && st.sp == bdm_pkg::STACK_PTR_FULL);
			next_st.unf = (stk.pop && !stk.push && st.sp == bdm_pkg::STACK_PTR_RESET);
		end
		// entry save overrides a same-cycle software shadow write
		if (irq_entry) begin
			next_kp.shadow = live_ctx;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{cls: bdm_pkg::BDM_CLS_NONE, sp: bdm_pkg::STACK_PTR_RESET, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// no reset on shadows and stack, so only power-up leaves them unknown
	always_ff @(posedge clk) begin
		kp <= next_kp;
	end

	bdm_ram u_ram (
		.clk(clk),
		// only decoded RAM locations are written
		.we(wr && cls == bdm_pkg::BDM_CLS_RAM),
		.addr(ram_idx),
		.wdata(req.wdata),
		.rdata(ram_q)
	);

	always_comb begin
		periph.valid = req.valid && cls == bdm_pkg::BDM_CLS_PERIPH;
		periph.we = wr && cls == bdm_pkg::BDM_CLS_PERIPH;
		periph.addr = ea[11:0];
		periph.wdata = req.wdata;
		rsp.valid = st.rsp_valid;
		rsp.cls = st.cls;
		rsp.addr = st.addr;
		rsp.prog_addr = st.prog_addr;
		rsp.rdata = (st.cls == bdm_pkg::BDM_CLS_RAM) ? ram_q : st.local_rdata;
	end

	// core reloads these when the handler returns
	assign restore_valid = irq_exit;
	assign restore_ctx = kp.shadow;
	assign tos = tos_cur;
	assign stack_reset_req = st.rst_req;
	assign stack_overflow = st.ovf;
	assign stack_underflow = st.unf;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_stack_over_reset: assert property (
		stk.push && st.sp == bdm_pkg::STACK_PTR_FULL && stack_fault_reset_enable
		|=> stack_reset_req && stack_overflow && st.sp == bdm_pkg::STACK_PTR_FULL)
		else $error("overflow did not request reset");
	chk_under_no_reset: assert property (
		stk.pop && !stk.push && st.sp == bdm_pkg::STACK_PTR_RESET && !stack_fault_reset_enable
		|=> !stack_reset_req && stack_underflow)
		else $error("underflow reset while disabled");
	chk_shadow_save: assert property (
		irq_entry |=> restore_ctx == $past(live_ctx))
		else $error("context not saved on entry");
	chk_restore_after_entry: assert property (
		irq_entry ##1 (!irq_entry && !wr) [*3] ##1 irq_exit
		|-> restore_valid && restore_ctx == $past(live_ctx, 4))
		else $error("restore does not match saved context");
	chk_periph_decode: assert property (
		req.valid && req.mode == bdm_pkg::BDM_DIRECT
		&& req.offset >= bdm_pkg::PERIPH_FIRST && req.offset <= bdm_pkg::PERIPH_LAST
		|-> periph.valid && periph.addr == {live_ctx.bank, req.offset})
		else $error("peripheral offset not decoded");
	chk_unimpl_zero: assert property (
		rsp.valid
		&& rsp.cls inside {bdm_pkg::BDM_CLS_NONE, bdm_pkg::BDM_CLS_CORE, bdm_pkg::BDM_CLS_PROG}
		|-> rsp.rdata == 8'h00)
		else $error("unimplemented read not zero");
	chk_common_alias: assert property (
		req.valid && req.mode == bdm_pkg::BDM_DIRECT && req.offset >= bdm_pkg::COMMON_FIRST
		|-> ram_idx == bdm_pkg::COMMON_BASE + 10'(req.offset[3:0]))
		else $error("common RAM not bank independent");
	chk_linear_map: assert property (
		req.valid && req.mode == bdm_pkg::BDM_IND0
		&& live_ctx.ptr0 >= bdm_pkg::LINEAR_BASE && live_ctx.ptr0 <= bdm_pkg::LINEAR_LAST
		|=> rsp.cls == bdm_pkg::BDM_CLS_RAM && $past(ram_idx) == $past(live_ctx.ptr0[9:0]))
		else $error("linear window misplaced");
	chk_direct_bank: assert property (
		req.valid && req.mode == bdm_pkg::BDM_DIRECT
		|=> rsp.valid && rsp.addr == {$past(live_ctx.bank), $past(req.offset)})
		else $error("direct address not bank and offset");
	chk_shadow_write: assert property (
		wr && !irq_entry && ea == {4'h0, bdm_pkg::ADDR_W_SHAD}
		|=> restore_ctx.w == $past(req.wdata))
		else $error("shadow write lost");

	cov_overflow: cover property (stk.push && st.sp == bdm_pkg::STACK_PTR_FULL);
	cov_irq_pair: cover property (irq_entry ##[1:20] irq_exit);
	cov_linear_read: cover property (req.valid && !req.we && req.mode == bdm_pkg::BDM_IND1
		&& live_ctx.ptr1 >= bdm_pkg::LINEAR_BASE && live_ctx.ptr1 <= bdm_pkg::LINEAR_LAST);
	cov_prog_read: cover property (rsp.valid && rsp.cls == bdm_pkg::BDM_CLS_PROG);
endmodule : bdm_core_map

// *** core/bdm_pkg.sv ***
package bdm_pkg;

	// Data space geometry: 32 banks of 128 locations
	localparam int unsigned BANK_W = 5;
	localparam int unsigned OFF_W = 7;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned RAM_AW = 10;
	localparam int unsigned RAM_DEPTH = 1024;
	localparam int unsigned STACK_DEPTH = 16;
	localparam int unsigned PC_W = 15;

	localparam logic [6:0] PERIPH_FIRST = 7'h0C;
	localparam logic [6:0] PERIPH_LAST = 7'h1F;
	localparam logic [6:0] RAM_FIRST = 7'h20;
	localparam logic [6:0] SPECIAL_FIRST = 7'h64;
	localparam logic [6:0] COMMON_FIRST = 7'h70;
	localparam logic [4:0] TOP_BANK = 5'h1F;
	localparam logic [4:0] RAM_BANKS = 5'h08;
	localparam logic [9:0] RAM_PER_BANK = 10'h050;
	localparam logic [9:0] COMMON_BASE = 10'h280;

	// Pointer space: banked window, linear RAM window, program memory
	localparam logic [15:0] BANKED_LIMIT = 16'h1000;
	localparam logic [15:0] LINEAR_BASE = 16'h2000;
	localparam logic [15:0] LINEAR_LAST = 16'h227F;
	localparam logic [15:0] PROG_BASE = 16'h8000;

	// Top-bank core registers
	localparam logic [11:0] ADDR_STATUS_SHADOW = 12'hFE4;
	localparam logic [11:0] ADDR_W_SHAD = 12'hFE5;
	localparam logic [11:0] ADDR_BANK_SHAD = 12'hFE6;
	localparam logic [11:0] ADDR_PROG_LATCH_SHADOW = 12'hFE7;
	localparam logic [11:0] ADDR_P0L_SHAD = 12'hFE8;
	localparam logic [11:0] ADDR_P0H_SHAD = 12'hFE9;
	localparam logic [11:0] ADDR_P1L_SHAD = 12'hFEA;
	localparam logic [11:0] ADDR_P1H_SHAD = 12'hFEB;
	localparam logic [11:0] ADDR_STACK_PTR = 12'hFED;
	localparam logic [11:0] ADDR_TOS_LOW = 12'hFEE;
	localparam logic [11:0] ADDR_TOS_HIGH = 12'hFEF;

	localparam logic [4:0] STACK_PTR_RESET = 5'h1F;
	localparam logic [4:0] STACK_PTR_FULL = 5'h0F;

	typedef enum logic [1:0] {
		BDM_DIRECT,
		BDM_IND0,
		BDM_IND1,
		BDM_REL
	} bdm_mode_t;

	typedef enum logic [2:0] {
		BDM_CLS_NONE,
		BDM_CLS_CORE,
		BDM_CLS_PERIPH,
		BDM_CLS_RAM,
		BDM_CLS_SPECIAL,
		BDM_CLS_PROG
	} bdm_cls_t;

	typedef struct packed {
		logic [2:0] status;
		logic [7:0] w;
		logic [4:0] bank;
		logic [6:0] prog_latch;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
	} bdm_ctx_t;

	typedef struct packed {
		logic valid;
		logic we;
		bdm_mode_t mode;
		logic [6:0] offset;
		logic [7:0] wdata;
		logic [8:0] rel_disp;
		logic [14:0] pc;
	} bdm_req_t;

	typedef struct packed {
		logic valid;
		bdm_cls_t cls;
		logic [11:0] addr;
		logic [14:0] prog_addr;
		logic [7:0] rdata;
	} bdm_rsp_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [11:0] addr;
		logic [7:0] wdata;
	} bdm_periph_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic [14:0] data;
	} bdm_stack_ctl_t;

endpackage : bdm_pkg

// *** core/bdm_ram.sv ***
`timescale 1ns/10ps
// General RAM and common RAM storage; read data leave through a register
module bdm_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic [bdm_pkg::RAM_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [bdm_pkg::RAM_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : bdm_ram

// *** test/bdm_periph_model.sv ***
`timescale 1ns/10ps
// Peripheral side answers reads in the same cycle; idle data toggle so stale values never match
module bdm_periph_model (
	input wire logic clk,
	input bdm_pkg::bdm_periph_t periph,
	output logic [7:0] periph_rdata
);
	logic idle_flip = 1'b0;
	always @(posedge clk) begin
		idle_flip <= ~idle_flip;
	end
	assign periph_rdata = periph.valid ? (periph.addr[7:0] ^ 8'h5A) : {8{idle_flip}};
endmodule : bdm_periph_model

// *** test/test_banked_data_memory_core_map.sv ***
`timescale 1ns/10ps
module test_banked_data_memory_core_map;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	bdm_pkg::bdm_req_t req = '0;
	bdm_pkg::bdm_ctx_t live_ctx = '0;
	bdm_pkg::bdm_ctx_t ctx = {3'h5, 8'hC3, 5'h1F, 7'h2A, 16'h20A5, 16'h8123};
	logic irq_entry = 1'b0;
	logic irq_exit = 1'b0;
	bdm_pkg::bdm_stack_ctl_t stk = '0;
	logic stack_fault_reset_enable = 1'b0;
	logic fault_flag_clear = 1'b0;
	logic [7:0] periph_rdata;
	bdm_pkg::bdm_periph_t periph;
	bdm_pkg::bdm_periph_t p;
	bdm_pkg::bdm_rsp_t rsp;
	bdm_pkg::bdm_rsp_t r;
	logic restore_valid;
	bdm_pkg::bdm_ctx_t restore_ctx;
	logic [14:0] tos;
	logic stack_reset_req;
	logic stack_overflow;
	logic stack_underflow;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	bdm_core_map u_dut (
		.clk(clk),
		.arst_n(arst_n),
		.req(req),
		.live_ctx(live_ctx),
		.irq_entry(irq_entry),
		.irq_exit(irq_exit),
		.stk(stk),
		.stack_fault_reset_enable(stack_fault_reset_enable),
		.fault_flag_clear(fault_flag_clear),
		.periph_rdata(periph_rdata),
		.periph(periph),
		.rsp(rsp),
		.restore_valid(restore_valid),
		.restore_ctx(restore_ctx),
		.tos(tos),
		.stack_reset_req(stack_reset_req),
		.stack_overflow(stack_overflow),
		.stack_underflow(stack_underflow)
	);

	bdm_periph_model u_periph (
		.clk(clk),
		.periph(periph),
		.periph_rdata(periph_rdata)
	);

	task automatic test_done();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// Cuts a hang short well past the expected ninety or so cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One access; periph sampled in the request cycle, rsp in the answer cycle
	task automatic acc(input logic we, input logic [4:0] bk, input logic [6:0] off,
			input logic [7:0] wd, input bdm_pkg::bdm_mode_t m = bdm_pkg::BDM_DIRECT);
		@(posedge clk);
		live_ctx.bank <= bk;
		req.valid <= 1'b1;
		req.we <= we;
		req.mode <= m;
		req.offset <= off;
		req.wdata <= wd;
		#1 p = periph;
		@(posedge clk);
		req.valid <= 1'b0;
		#1 r = rsp;
	endtask : acc

	task automatic test_ram();
		acc(1'b1, 5'h02, 7'h25, 8'hB4);
		acc(1'b0, 5'h02, 7'h25, 8'h00);
		chk("ram cls", bdm_pkg::BDM_CLS_RAM, r.cls);
		chk("ram addr", 12'h125, r.addr);
		chk("rsp valid", 1'b1, r.valid);
		chk("ram data", 8'hB4, r.rdata);
		acc(1'b0, 5'h00, 7'h00, 8'h00, bdm_pkg::BDM_IND0);
		chk("linear data", 8'hB4, r.rdata);
		acc(1'b1, 5'h00, 7'h75, 8'h3C);
		acc(1'b0, 5'h06, 7'h75, 8'h00);
		chk("common data", 8'h3C, r.rdata);
		$display("Test ram done");
	endtask : test_ram

	task automatic test_decode();
		acc(1'b0, 5'h04, 7'h1F, 8'h00);
		chk("periph valid", 1'b1, p.valid);
		chk("periph addr", 12'h21F, p.addr);
		chk("periph data", 8'h45, r.rdata);
		acc(1'b1, 5'h04, 7'h0C, 8'hA7);
		chk("periph we", 1'b1, p.we);
		chk("periph wdata", 8'hA7, p.wdata);
		acc(1'b1, 5'h09, 7'h30, 8'hFF);
		acc(1'b0, 5'h09, 7'h30, 8'h00);
		chk("unmapped cls", bdm_pkg::BDM_CLS_NONE, r.cls);
		chk("unmapped data", 8'h00, r.rdata);
		acc(1'b0, 5'h1F, 7'h6C, 8'h00);
		chk("hole data", 8'h00, r.rdata);
		acc(1'b0, 5'h00, 7'h00, 8'h00, bdm_pkg::BDM_IND1);
		chk("prog cls", bdm_pkg::BDM_CLS_PROG, r.cls);
		chk("prog addr", 15'h0123, r.prog_addr);
		acc(1'b0, 5'h00, 7'h00, 8'h00, bdm_pkg::BDM_REL);
		chk("rel addr", 15'h00FE, r.prog_addr);
		$display("Test decode done");
	endtask : test_decode

	task automatic test_irq();
		@(posedge clk);
		live_ctx <= ctx;
		irq_entry <= 1'b1;
		@(posedge clk);
		irq_entry <= 1'b0;
		live_ctx.w <= 8'h11;
		#1 chk("saved ctx", ctx, restore_ctx);
		acc(1'b1, 5'h1F, 7'h65, 8'h77);
		acc(1'b0, 5'h1F, 7'h64, 8'h00);
		chk("status shadow", 8'h05, r.rdata);
		@(posedge clk);
		irq_exit <= 1'b1;
		#1 chk("restore valid", 1'b1, restore_valid);
		chk("restored w", 8'h77, restore_ctx.w);
		@(posedge clk);
		irq_exit <= 1'b0;
		// Second entry with a quiet handler: exit must bring back the w value saved at entry
		live_ctx.w <= 8'h3E;
		irq_entry <= 1'b1;
		@(posedge clk);
		irq_entry <= 1'b0;
		live_ctx.w <= 8'h11;
		repeat (3) @(posedge clk);
		irq_exit <= 1'b1;
		#1 chk("second restore w", 8'h3E, restore_ctx.w);
		@(posedge clk);
		irq_exit <= 1'b0;
		$display("Test irq done");
	endtask : test_irq

	// Seventeen pushes; the last one exceeds sixteen entries
	task automatic test_overflow();
		@(posedge clk);
		stack_fault_reset_enable <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			stk.push <= 1'b1;
			stk.data <= 15'h0100 + 15'(i);
			@(posedge clk);
		end
		stk.push <= 1'b0;
		#1 chk("overflow", 1'b1, stack_overflow);
		chk("reset req", 1'b1, stack_reset_req);
		chk("tos kept", 15'h010F, tos);
		@(posedge clk);
		fault_flag_clear <= 1'b1;
		#1 chk("reset pulse", 1'b0, stack_reset_req);
		@(posedge clk);
		fault_flag_clear <= 1'b0;
		#1 chk("flag clear", 1'b0, stack_overflow);
		$display("Test overflow done");
	endtask : test_overflow

	task automatic test_reset();
		acc(1'b1, 5'h1F, 7'h65, 8'h5A);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		acc(1'b0, 5'h1F, 7'h65, 8'h00);
		chk("shadow kept", 8'h5A, r.rdata);
		acc(1'b0, 5'h1F, 7'h6D, 8'h00);
		chk("ptr reset", 8'h1F, r.rdata);
		chk("tos empty", 15'h0000, tos);
		$display("Test reset done");
	endtask : test_reset

	// Fault flag still rises when the reset request is disabled
	task automatic test_underflow();
		@(posedge clk);
		stack_fault_reset_enable <= 1'b0;
		stk.pop <= 1'b1;
		@(posedge clk);
		stk.pop <= 1'b0;
		#1 chk("underflow", 1'b1, stack_underflow);
		chk("no reset req", 1'b0, stack_reset_req);
		$display("Test underflow done");
	endtask : test_underflow

	initial begin
		live_ctx <= ctx;
		req.pc <= 15'h0100;
		req.rel_disp <= 9'h1FE;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		test_ram();
		test_decode();
		test_irq();
		test_overflow();
		test_reset();
		test_underflow();
		test_done();
	end
endmodule : test_banked_data_memory_core_map
